// File: rtl/obfp_defines.svh
`ifndef OBFP_DEFINES_SVH
`define OBFP_DEFINES_SVH
`define OBFP_CIB_BASE 32'h0804_0800
`define OBFP_FIB_BASE 32'h0804_0000
`define OBFP_MFB_BASE 32'h0800_0000
`define OBFP_BLOCK_BYTES 32'h0000_0800
`define OBFP_PAGE_BYTES 2048
`define OBFP_REGION_PAGES 4
`define OBFP_REGION_LSB 13
`define OBFP_OB_COUNT 8
`define OBFP_RP_OFF_KEY 8'ha5
`define OBFP_ERASED_BYTE 8'hff
`define OBFP_REG_STATUS 8'h00
`define OBFP_REG_CMD 8'h04
`define OBFP_REG_VAL_LO 8'h08
`define OBFP_REG_VAL_HI 8'h0c
`define OBFP_REG_WPMASK 8'h10
`define OBFP_CMD_ERASE_BIT 16
`endif

// File: rtl/obfp_pkg.sv
package obfp_pkg;
  typedef enum logic [1:0] {OBFP_LOAD_REQ, OBFP_LOAD_WAIT, OBFP_RUN, OBFP_HALT} obfp_state_type;
  typedef struct packed {
    logic fetch;
    logic [31:0] addr;
  } obfp_acc_type;
  typedef struct packed {
    logic erase;
    logic [31:0] addr;
  } obfp_op_type;
  typedef struct packed {
    logic erase;
    logic [31:0] addr;
    logic [15:0] data;
  } obfp_obwr_type;
endpackage

// File: rtl/obfp_option_guard.sv
`timescale 1ns/100ps
`include "obfp_defines.svh"
// Function
// [RULE_01] Option byte is a half-word: data low byte, its complement high byte.
// [RULE_02] Hardware builds the complement byte when programming; users cannot set it.
// [RULE_03] Loader checks each byte against its complement at reset; mismatch halts CPU.
// [RULE_04] Eight option bytes sit at consecutive half-words from the CUSTOMER_INFO_BLOCK start.
// [RULE_05] Customer info page is data only; instruction fetches are refused.
// [RULE_06] Each protect bit guards one 8 KB region, bit 0 of byte 4 first.
// [RULE_07] Large variant uses bytes 4..6 for 24 regions; small ignores byte 6.
// [RULE_08] Protect bits are active low; erased 0xFF leaves regions open.
// [RULE_09] New protect settings take effect only after the next reset reload.
// [RULE_10] Protected region refuses both half-word programming and page erase.
// [RULE_11] Read protection is off only when byte 0 holds 0xA5.
// [RULE_12] Read protection state changes only at a full chip reset.
// [RULE_13] An attached debugger sets an intrusion flag that stays latched.
// [RULE_14] Read protection plus intrusion disconnects every flash block from the bus.
// [RULE_15] Intrusion clears only by chip reset after the debugger is detached.
// [RULE_16] Byte 0 must be erased before programming; 0xA5 alone disables protection.
// [RULE_17] Erasing byte 0 under read protection mass-erases main flash.
// [RULE_18] Under read protection the bottom four pages are always write-protected.
// [RULE_19] Configurer should enable write protection together with read protection.
// [RULE_20] Bytes 2 and 3 drive nothing; they only get the integrity check.
// [RULE_21] Read protection covers main, factory info and customer info blocks.
// [RULE_22] Main flash uses 2048-byte pages; regions are four pages each.
// [RULE_23] Verified option bytes are held internally until the next reset.
module obfp_option_guard #(
  parameter int unsigned REGIONS = 24
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic obRdReq,
  output logic [31:0] obRdAddr,
  input wire logic [15:0] obRdData,
  input wire logic obRdValid,
  input wire logic accValid,
  input wire obfp_pkg::obfp_acc_type accReq,
  output logic accGrant,
  output logic accDeny,
  input wire logic opValid,
  input wire obfp_pkg::obfp_op_type opReq,
  output logic opGrant,
  output logic opReject,
  output logic obWrValid,
  output obfp_pkg::obfp_obwr_type obWr,
  input wire logic obWrDone,
  output logic massErase,
  input wire logic dbgAttach,
  output logic cpuHalt,
  output logic readProtActive,
  output logic intrusionFlag
);
  localparam logic [31:0] REGION_BYTES = 32'(`OBFP_PAGE_BYTES * `OBFP_REGION_PAGES);
  localparam logic [31:0] MFB_BYTES = 32'(REGIONS) * REGION_BYTES;

  // ==========================================
  // Helpers
  function automatic logic inBlock(input logic [31:0] a, base, size);
    logic [31:0] off;
    off = a - base;
    return off < size;
  endfunction

  // [RULE_04] Half-word slot address
  function automatic logic [31:0] slotAddr(input logic [2:0] idx);
    return `OBFP_CIB_BASE + {28'h0000000, idx, 1'b0};
  endfunction

  // [RULE_01] Complement check
  function automatic logic badPair(input logic [15:0] d);
    return d[15:8] != ~d[7:0];
  endfunction

  // ==========================================
  // Loader state
  obfp_pkg::obfp_state_type state_q, state_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] held_q [`OBFP_OB_COUNT];
  logic [7:0] held_d [`OBFP_OB_COUNT];
  logic rdReq_q, rdReq_d;
  logic [31:0] rdAddr_q, rdAddr_d;
  logic halt_q, halt_d;
  logic rp_q, rp_d;
  logic dbgMeta_q, dbgSync_q, intr_q, intr_d;

  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    held_d = held_q;
    rdReq_d = 1'b0;
    rdAddr_d = rdAddr_q;
    halt_d = halt_q;
    rp_d = rp_q;
    case (state_q)
      obfp_pkg::OBFP_LOAD_REQ:
      begin
        rdReq_d = 1'b1;
        rdAddr_d = slotAddr(idx_q);
        state_d = obfp_pkg::OBFP_LOAD_WAIT;
      end
      obfp_pkg::OBFP_LOAD_WAIT:
      begin
        if (obRdValid)
        begin
          // [RULE_03] Mismatch halts until the next reset
          if (badPair(obRdData))
            state_d = obfp_pkg::OBFP_HALT;
          else
          begin
            // [RULE_23] Held copy, only reset reloads it
            held_d[idx_q] = obRdData[7:0];
            if (idx_q == 3'(`OBFP_OB_COUNT - 1))
            begin
              state_d = obfp_pkg::OBFP_RUN;
              halt_d = 1'b0;
              // [RULE_11] Only the key opens the flash
              rp_d = held_d[0] != `OBFP_RP_OFF_KEY;
            end
            else
            begin
              idx_d = idx_q + 3'h1;
              state_d = obfp_pkg::OBFP_LOAD_REQ;
            end
          end
        end
      end
      default: state_d = state_q;
    endcase
    // [RULE_13] Latched until chip reset
    intr_d = intr_q | dbgSync_q;
  end

  // [RULE_12] Read protection and intrusion only reset here
  // [RULE_15] Chip reset is the sole clear of intrusion
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_q <= obfp_pkg::OBFP_LOAD_REQ;
      idx_q <= 3'h0;
      for (int i = 0; i < `OBFP_OB_COUNT; i++)
        held_q[i] <= `OBFP_ERASED_BYTE;
      rdReq_q <= 1'b0;
      rdAddr_q <= `OBFP_CIB_BASE;
      halt_q <= 1'b1;
      rp_q <= 1'b1;
      dbgMeta_q <= 1'b0;
      dbgSync_q <= 1'b0;
      intr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      held_q <= held_d;
      rdReq_q <= rdReq_d;
      rdAddr_q <= rdAddr_d;
      halt_q <= halt_d;
      rp_q <= rp_d;
      dbgMeta_q <= dbgAttach;
      dbgSync_q <= dbgMeta_q;
      intr_q <= intr_d;
    end
  end

  // ==========================================
  // Protection checks
  logic running, lockOut;
  logic [23:0] wpVec;
  logic [31:0] opOff;
  logic [4:0] opRegion;
  logic opProt;
  logic accGrant_q, accGrant_d, accDeny_q, accDeny_d;
  logic opGrant_q, opGrant_d, opReject_q, opReject_d;

  always_comb
  begin
    running = state_q == obfp_pkg::OBFP_RUN;
    // [RULE_14] Flash cut off under protection and intrusion
    lockOut = rp_q & intr_q;
    // [RULE_07] Byte 6 unused on the small variant
    // [RULE_20] Bytes 2 and 3 feed nothing here
    wpVec = {held_q[6], held_q[5], held_q[4]};
    opOff = opReq.addr - `OBFP_MFB_BASE;
    // [RULE_22] Region index from page grouping
    opRegion = opOff[`OBFP_REGION_LSB+4:`OBFP_REGION_LSB];
    opProt = 1'b1;
    // [RULE_06] One active-low bit per region
    // [RULE_08] Cleared bit protects
    if (opOff < MFB_BYTES)
    begin
      opProt = ~wpVec[opRegion];
      // [RULE_18] Boot region locked under read protection
      if (rp_q && opRegion == 5'h00)
        opProt = 1'b1;
    end
    // [RULE_10] Program and erase both refused
    // [RULE_09] Only held values are consulted
    opGrant_d = opValid & running & ~lockOut & ~opProt;
    opReject_d = opValid & ~opGrant_d;
    accGrant_d = 1'b0;
    accDeny_d = 1'b0;
    if (accValid)
    begin
      accDeny_d = ~running;
      // [RULE_21] All three blocks covered
      if (lockOut && (inBlock(accReq.addr, `OBFP_MFB_BASE, MFB_BYTES)
          || inBlock(accReq.addr, `OBFP_FIB_BASE, `OBFP_BLOCK_BYTES)
          || inBlock(accReq.addr, `OBFP_CIB_BASE, `OBFP_BLOCK_BYTES)))
        accDeny_d = 1'b1;
      // [RULE_05] No fetch from customer page
      if (accReq.fetch && inBlock(accReq.addr, `OBFP_CIB_BASE, `OBFP_BLOCK_BYTES))
        accDeny_d = 1'b1;
      accGrant_d = ~accDeny_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      accGrant_q <= 1'b0;
      accDeny_q <= 1'b0;
      opGrant_q <= 1'b0;
      opReject_q <= 1'b0;
    end
    else
    begin
      accGrant_q <= accGrant_d;
      accDeny_q <= accDeny_d;
      opGrant_q <= opGrant_d;
      opReject_q <= opReject_d;
    end
  end

  // ==========================================
  // Option programming and register bus
  logic wbReq, cmdWrite;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic wrValid_q, wrValid_d;
  obfp_pkg::obfp_obwr_type wr_q, wr_d;
  logic mass_q, mass_d;
  logic ob0Erased_q, ob0Erased_d;
  logic refused_q, refused_d;
  logic [2:0] cmdIdx;

  always_comb
  begin
    wbReq = wb_cyc_i & wb_stb_i & ~ack_q;
    // Partial writes are ignored so a half-built command never starts
    cmdWrite = wbReq & wb_we_i & (wb_adr_i == `OBFP_REG_CMD) & (wb_sel_i == 4'hf);
    cmdIdx = wb_dat_i[10:8];
    ack_d = wbReq;
    dat_d = 32'h0000_0000;
    wrValid_d = wrValid_q & ~obWrDone;
    wr_d = wr_q;
    mass_d = 1'b0;
    ob0Erased_d = ob0Erased_q;
    refused_d = refused_q;
    if (wbReq && !wb_we_i)
    begin
      if (wb_adr_i == `OBFP_REG_STATUS)
        dat_d = {26'h0, refused_q, wrValid_q, intr_q, rp_q,
                 state_q == obfp_pkg::OBFP_HALT, running};
      else if (wb_adr_i == `OBFP_REG_VAL_LO)
        dat_d = {held_q[3], held_q[2], held_q[1], held_q[0]};
      else if (wb_adr_i == `OBFP_REG_VAL_HI)
        dat_d = {held_q[7], held_q[6], held_q[5], held_q[4]};
      else if (wb_adr_i == `OBFP_REG_WPMASK)
        dat_d = {8'h00, wpVec};
    end
    if (cmdWrite)
    begin
      refused_d = 1'b1;
      if (running && !wrValid_q)
      begin
        if (wb_dat_i[`OBFP_CMD_ERASE_BIT])
        begin
          refused_d = 1'b0;
          wrValid_d = 1'b1;
          wr_d.erase = 1'b1;
          wr_d.addr = slotAddr(cmdIdx);
          wr_d.data = {`OBFP_ERASED_BYTE, `OBFP_ERASED_BYTE};
          if (cmdIdx == 3'h0)
          begin
            ob0Erased_d = 1'b1;
            // [RULE_17] Unlocking wipes main flash
            mass_d = rp_q;
          end
        end
        // [RULE_16] Byte 0 needs an erase first
        else if (cmdIdx != 3'h0 || ob0Erased_q)
        begin
          refused_d = 1'b0;
          wrValid_d = 1'b1;
          wr_d.erase = 1'b0;
          wr_d.addr = slotAddr(cmdIdx);
          // [RULE_02] Upper byte generated here
          wr_d.data = {~wb_dat_i[7:0], wb_dat_i[7:0]};
          if (cmdIdx == 3'h0)
            ob0Erased_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      wrValid_q <= 1'b0;
      wr_q <= '0;
      mass_q <= 1'b0;
      ob0Erased_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      wrValid_q <= wrValid_d;
      wr_q <= wr_d;
      mass_q <= mass_d;
      ob0Erased_q <= ob0Erased_d;
      refused_q <= refused_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign obRdReq = rdReq_q;
  assign obRdAddr = rdAddr_q;
  assign accGrant = accGrant_q;
  assign accDeny = accDeny_q;
  assign opGrant = opGrant_q;
  assign opReject = opReject_q;
  assign obWrValid = wrValid_q;
  assign obWr = wr_q;
  assign massErase = mass_q;
  assign cpuHalt = halt_q;
  assign readProtActive = rp_q;
  assign intrusionFlag = intr_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_halt_on_bad: assert property ( // [RULE_03]
    state_q == obfp_pkg::OBFP_LOAD_WAIT && obRdValid && badPair(obRdData)
    |=> cpuHalt && state_q == obfp_pkg::OBFP_HALT [*3])
    else $error("halt missing after bad option pair");
  a_slot_addr: assert property ( // [RULE_04]
    obRdReq |-> obRdAddr == `OBFP_CIB_BASE + {28'h0000000, idx_q, 1'b0})
    else $error("option read address wrong");
  a_complement_gen: assert property ( // [RULE_02]
    obWrValid && !obWr.erase |-> obWr.data[15:8] == ~obWr.data[7:0])
    else $error("programmed half-word lacks complement");
  a_cib_fetch: assert property ( // [RULE_05]
    accValid && accReq.fetch && accReq.addr == `OBFP_CIB_BASE |=> accDeny && !accGrant)
    else $error("fetch from customer page allowed");
  // Third region, so the bench's protected-region request reaches this check
  a_wp_reject: assert property ( // [RULE_10]
    opValid && opReq.addr == `OBFP_MFB_BASE + 2 * REGION_BYTES && !held_q[4][2]
    |=> opReject && !opGrant)
    else $error("protected region not refused");
  a_boot_lock: assert property ( // [RULE_18]
    opValid && rp_q && opReq.addr == `OBFP_MFB_BASE |=> opReject)
    else $error("boot pages writable under read protection");
  a_lockout_deny: assert property ( // [RULE_14]
    accValid && readProtActive && intrusionFlag && accReq.addr == `OBFP_FIB_BASE
    |=> accDeny)
    else $error("flash reachable during lockout");
  a_intr_latched: assert property ( // [RULE_13]
    intrusionFlag |=> intrusionFlag)
    else $error("intrusion flag dropped");
  a_rp_stable: assert property ( // [RULE_12]
    state_q == obfp_pkg::OBFP_RUN |=> $stable(readProtActive))
    else $error("read protection changed while running");
  a_mass_erase: assert property ( // [RULE_17]
    cmdWrite && running && !wrValid_q && wb_dat_i[`OBFP_CMD_ERASE_BIT]
    && cmdIdx == 3'h0 && rp_q |=> massErase ##1 !massErase)
    else $error("mass erase not raised");
  c_load_done: cover property (state_q == obfp_pkg::OBFP_LOAD_WAIT ##1 running);
  c_halt: cover property (state_q == obfp_pkg::OBFP_HALT);
  c_mass: cover property (massErase);
  c_lockout: cover property (accDeny && readProtActive && intrusionFlag);
endmodule

// File: bench/obfp_flash_model.sv
`timescale 1ns/100ps
// ==========================================
// Flash array behind the option byte loader
module obfp_flash_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic preset,
  input wire logic slow,
  input wire logic [7:0][15:0] image,
  input wire logic obRdReq,
  input wire logic [31:0] obRdAddr,
  output logic [15:0] obRdData,
  output logic obRdValid,
  input wire logic obWrValid,
  input wire obfp_pkg::obfp_obwr_type obWr,
  output logic obWrDone
);
  logic [7:0][15:0] mem;
  logic [2:0] idx;
  logic [3:0] cnt;
  logic [1:0] wcnt;
  logic busy;
  logic okAddr;
  always @(posedge ref_clk)
  begin
    if (preset)
      mem <= image;
    else if (obWrDone)
      mem[obWr.addr[3:1]] <= obWr.erase ? 16'hffff : (mem[obWr.addr[3:1]] & obWr.data);
    if (!rst_b)
    begin
      busy <= 1'b0;
      obRdValid <= 1'b0;
      obRdData <= 16'h0000;
      obWrDone <= 1'b0;
      wcnt <= 2'h0;
    end
    else
    begin
      // Toggle between answers so stale data never looks valid
      obRdValid <= 1'b0;
      obRdData <= ~obRdData;
      if (obRdReq)
      begin
        busy <= 1'b1;
        idx <= obRdAddr[3:1];
        cnt <= slow ? 4'h6 : 4'h0;
        okAddr <= (obRdAddr[31:4] == 28'h0804080);
      end
      else if (busy && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (busy)
      begin
        busy <= 1'b0;
        obRdValid <= 1'b1;
        obRdData <= okAddr ? mem[idx] : 16'h0000;
      end
      obWrDone <= 1'b0;
      if (obWrValid && !obWrDone)
      begin
        wcnt <= wcnt + 2'h1;
        obWrDone <= (wcnt == 2'h3);
      end
    end
  end
endmodule

// File: bench/option_byte_flash_protection_tb_top.sv
`timescale 1ns/100ps
module option_byte_flash_protection_tb_top;
  // ==========================================
  // Signals
  logic ref_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic accValid = 1'b0, opValid = 1'b0, dbgAttach = 1'b0, slow = 1'b0, preset = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, dato, rdAddr, r;
  logic [31:0] meCnt = 32'h0;
  logic [15:0] rdData;
  logic [7:0][15:0] image = '0;
  logic ack, rdReq, rdValid, wrValid, wrDone, accGrant, accDeny, opGrant, opReject;
  logic massErase, cpuHalt, readProtActive, intrusionFlag;
  obfp_pkg::obfp_acc_type accReq = '0;
  obfp_pkg::obfp_op_type opReq = '0;
  obfp_pkg::obfp_obwr_type obWr, lastWr;
  int err_total = 0, checks_done = 0;
  always #12.5 ref_clk = ~ref_clk;
  obfp_option_guard #(.REGIONS(24)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack), .obRdReq(rdReq), .obRdAddr(rdAddr),
    .obRdData(rdData), .obRdValid(rdValid), .accValid(accValid), .accReq(accReq),
    .accGrant(accGrant), .accDeny(accDeny), .opValid(opValid), .opReq(opReq),
    .opGrant(opGrant), .opReject(opReject), .obWrValid(wrValid), .obWr(obWr),
    .obWrDone(wrDone), .massErase(massErase), .dbgAttach(dbgAttach), .cpuHalt(cpuHalt),
    .readProtActive(readProtActive), .intrusionFlag(intrusionFlag));
  obfp_flash_model u_flash (.ref_clk(ref_clk), .rst_b(rst_b), .preset(preset), .slow(slow),
    .image(image), .obRdReq(rdReq), .obRdAddr(rdAddr), .obRdData(rdData),
    .obRdValid(rdValid), .obWrValid(wrValid), .obWr(obWr), .obWrDone(wrDone));
  always @(posedge ref_clk)
  begin
    if (massErase === 1'b1)
      meCnt <= meCnt + 32'h1;
    if (wrValid === 1'b1)
      lastWr <= obWr;
  end
  // ==========================================
  // Helpers
  function automatic logic [15:0] hw(input logic [7:0] b);
    return {~b, b};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge ref_clk);
    while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic cmd(input logic [31:0] d);
    wb(1'b1, 8'h04, d, r);
    for (int i = 0; i < 50 && wrValid !== 1'b0; i++)
      @(posedge ref_clk);
  endtask
  task automatic opc(input logic e, input logic [31:0] a, input logic g);
    @(posedge ref_clk);
    opValid <= 1'b1;
    opReq <= '{erase: e, addr: a};
    @(posedge ref_clk);
    opValid <= 1'b0;
    @(posedge ref_clk);
    chk({30'h0, opGrant, opReject}, {30'h0, g, ~g});
  endtask
  task automatic accc(input logic f, input logic [31:0] a, input logic g);
    @(posedge ref_clk);
    accValid <= 1'b1;
    accReq <= '{fetch: f, addr: a};
    @(posedge ref_clk);
    accValid <= 1'b0;
    @(posedge ref_clk);
    chk({30'h0, accGrant, accDeny}, {30'h0, g, ~g});
  endtask
  task automatic boot(input logic [7:0][15:0] img, input logic ld);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    preset <= ld;
    image <= img;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    preset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 200 && cpuHalt !== 1'b0; i++)
      @(posedge ref_clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic tLoad;
    slow <= 1'b1;
    // Read protection paired with write protection
    boot({hw(8'hff), hw(8'h7f), hw(8'hff), hw(8'hfb), hw(8'h33), hw(8'h22), hw(8'hff),
      hw(8'hff)}, 1'b1);
    rd(8'h00, 32'h0000_0005);
    rd(8'h08, 32'h3322_ffff);
    rd(8'h0c, 32'hff7f_fffb);
    rd(8'h10, 32'h007f_fffb);
    rd(8'h20, 32'h0000_0000);
    opc(1'b0, 32'h0800_0000, 1'b0);
    opc(1'b1, 32'h0800_2000, 1'b1);
    opc(1'b1, 32'h0800_4000, 1'b0);
    opc(1'b0, 32'h0800_5ffe, 1'b0);
    opc(1'b0, 32'h0800_6000, 1'b1);
    opc(1'b0, 32'h0802_e000, 1'b0);
    opc(1'b0, 32'h0802_dffe, 1'b1);
    accc(1'b1, 32'h0804_0800, 1'b0);
    accc(1'b0, 32'h0804_0800, 1'b1);
  endtask
  task automatic tIntrude;
    dbgAttach <= 1'b1;
    repeat (5) @(posedge ref_clk);
    dbgAttach <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk({31'h0, intrusionFlag}, 32'h1);
    rd(8'h00, 32'h0000_000d);
    accc(1'b0, 32'h0800_2000, 1'b0);
    accc(1'b0, 32'h0804_0000, 1'b0);
    accc(1'b0, 32'h0804_0800, 1'b0);
    opc(1'b0, 32'h0800_2000, 1'b0);
    boot(image, 1'b0);
    chk({31'h0, intrusionFlag}, 32'h0);
    accc(1'b1, 32'h0800_2000, 1'b1);
  endtask
  task automatic tOptWrite;
    cmd(32'h0000_00a5);
    rd(8'h00, 32'h0000_0025);
    cmd(32'h0001_0000);
    chk(meCnt, 32'h1);
    chk({lastWr.addr[15:0], lastWr.data}, 32'h0800_ffff);
    cmd(32'h0000_00a5);
    chk({lastWr.addr[15:0], lastWr.data}, 32'h0800_5aa5);
    cmd(32'h0000_00a5);
    rd(8'h00, 32'h0000_0025);
    chk({31'h0, readProtActive}, 32'h1);
    rd(8'h08, 32'h3322_ffff);
    slow <= 1'b0;
    boot(image, 1'b0);
    chk({31'h0, readProtActive}, 32'h0);
    opc(1'b0, 32'h0800_0000, 1'b1);
    cmd(32'h0001_0000);
    chk(meCnt, 32'h1);
  endtask
  task automatic tBadLoad;
    boot({hw(8'hff), hw(8'hff), hw(8'hff), hw(8'hff), 16'h0033, hw(8'h22), hw(8'hff),
      hw(8'ha5)}, 1'b1);
    chk({31'h0, cpuHalt}, 32'h1);
    rd(8'h00, 32'h0000_0006);
    accc(1'b0, 32'h0800_2000, 1'b0);
  endtask
  // ==========================================
  // Run control
  task automatic results;
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    tLoad();
    tIntrude();
    tOptWrite();
    tBadLoad();
    results();
  end
  // Whole run is under 1000 cycles, so this only trips on a hang
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    results();
  end
endmodule
